// ### shared/rsq_map.vh
/*
  Register map, field positions, reset values and timing counts of the
  system reset sequencer. Assumes a 250 MHz core clock and 32-bit AXI4-Lite.
*/
`ifndef RSQ_MAP_VH
`define RSQ_MAP_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RSQ_OFS_CTRL 8'h00
`define RSQ_OFS_WDOG 8'h04
`define RSQ_OFS_RSTST 8'h08
`define RSQ_OFS_IRQST 8'h0c
`define RSQ_OFS_IRQMSK 8'h10

// ****************************************
// Control register fields
// ****************************************
`define RSQ_CTRL_PIN_EN 0
`define RSQ_CTRL_WDOG_EN 1
`define RSQ_CTRL_LVL_LO 2
`define RSQ_CTRL_LVL_HI 3
`define RSQ_CTRL_LVRST_EN 4
`define RSQ_CTRL_RESET 5'h11

// ****************************************
// Reset status fields
// ****************************************
`define RSQ_RST_PIN 0
`define RSQ_RST_WDOG 1
`define RSQ_RST_LV 2
`define RSQ_RST_POWER 3
`define RSQ_RST_LV_LIVE 4
`define RSQ_RSTST_RESET 4'h8

// ****************************************
// Interrupt status and mask fields
// ****************************************
`define RSQ_IRQ_LV 0
`define RSQ_IRQ_WDOG 1

// ****************************************
// Timing
// ****************************************
`define RSQ_CLK_MHZ 250
`define RSQ_INIT_NS 64
`define RSQ_WARMUP_NS 2000
`define RSQ_INIT_CYC ((`RSQ_INIT_NS * `RSQ_CLK_MHZ + 999) / 1000)
`define RSQ_WARMUP_CYC ((`RSQ_WARMUP_NS * `RSQ_CLK_MHZ + 999) / 1000)
`define RSQ_WDOG_WIDTH 20
`define RSQ_BOOT_ADDR 32'h1fff_0000

`endif

// ### logic/rsq_sync3.v
/*
  Three-stage input synchroniser, one lane per bit. A new level is
  accepted once the second and third stage agree.
  Assumes asynchronous inputs and a single destination clock.
*/
`timescale 1ns/100ps

module rsq_sync3 #(
  parameter WIDTH = 1
) (
  input wire clk,               // Destination clock
  input wire arst_n,            // Async reset, active low
  input wire [WIDTH-1:0] din,   // Asynchronous levels
  output wire [WIDTH-1:0] dout  // Filtered synchronous levels
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : lane
      reg s1;
      reg s2;
      reg s3;
      reg q;
      always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          s1 <= 1'b0;
          s2 <= 1'b0;
          s3 <= 1'b0;
          q <= 1'b0;
        end else begin
          s1 <= din[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            q <= s3;
          end
        end
      end
      assign dout[i] = q;
    end
  endgenerate

endmodule

// ### logic/rsq_wdog.v
/*
  Free-running watchdog counter with software clear and overflow pulse.
  Assumes clear and enable come from logic on the same clock.
*/
`timescale 1ns/100ps

module rsq_wdog #(
  parameter WIDTH = 20
) (
  input wire clk,               // Core clock
  input wire arst_n,            // Async reset, active low
  input wire enable,            // Counting allowed
  input wire clear,             // Restart from zero
  output reg [WIDTH-1:0] count, // Current count
  output reg overflow           // One-cycle overflow pulse
);

  wire at_top = &count;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= {WIDTH{1'b0}};
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (clear) begin
        count <= {WIDTH{1'b0}};
      end else if (enable) begin
        // No stop or saturation: only a clear saves the system
        count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        if (at_top) begin
          overflow <= 1'b1;
        end
      end
    end
  end

endmodule

// ### logic/rsq_top.v
/*
  System reset sequencer: combines pin, watchdog and low-voltage reset
  causes, runs hold / init / warm-up / run, records causes, and offers an
  AXI4-Lite register slave with a masked interrupt.
  Assumes asynchronous pin and detector inputs and a single core clock.

  // Function
  // - Watchdog overflow raises full system reset.
  // - Watchdog counts until overflow unless cleared.
  // - After watchdog reset: init, warm-up, release.
  // - Watchdog reset restarts at address zero.
  // - Low supply raises interrupt request line.
  // - Low-voltage level readable as status bit.
  // - Selectable second threshold forces chip reset.
  // - Pin reset enable bit, resets to one.
  // - Reset pin is active low.
  // - Enabled pin not high holds system reset.
  // - Pin reset acts at power-up and running.
  // - Pin release: init, warm-up, boot loader.
  // - Reset cause flags readable by software.
*/
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "rsq_map.vh"

module rsq_top #(
  parameter WDOG_WIDTH = `RSQ_WDOG_WIDTH,
  parameter INIT_CYCLES = `RSQ_INIT_CYC,
  parameter WARMUP_CYCLES = `RSQ_WARMUP_CYC,
  parameter [31:0] BOOT_ADDR = `RSQ_BOOT_ADDR
) (
  input wire CORE_CLK,             // Core clock, 250 MHz
  input wire ARST_N,               // Power-on reset, active low
  input wire S_AXI_AWVALID,        // Write address valid
  output reg S_AXI_AWREADY,        // Write address ready
  input wire [7:0] S_AXI_AWADDR,   // Write byte address
  input wire S_AXI_WVALID,         // Write data valid
  output reg S_AXI_WREADY,         // Write data ready
  input wire [31:0] S_AXI_WDATA,   // Write data
  input wire [3:0] S_AXI_WSTRB,    // Write byte strobes
  output reg S_AXI_BVALID,         // Write response valid
  input wire S_AXI_BREADY,         // Write response ready
  output reg [1:0] S_AXI_BRESP,    // Write response code
  input wire S_AXI_ARVALID,        // Read address valid
  output reg S_AXI_ARREADY,        // Read address ready
  input wire [7:0] S_AXI_ARADDR,   // Read byte address
  output reg S_AXI_RVALID,         // Read data valid
  input wire S_AXI_RREADY,         // Read data ready
  output reg [31:0] S_AXI_RDATA,   // Read data
  output reg [1:0] S_AXI_RRESP,    // Read response code
  input wire PIN_RST_N,            // External reset pin, active low
  input wire LV_DETECT,            // Supply below detect level
  input wire LV_TRIP,              // Supply below selected reset level
  output reg [1:0] LV_RESET_LEVEL, // Second threshold select
  output reg LV_IRQ,               // Request to interrupt controller
  output reg IRQ,                  // Masked status interrupt
  output reg SYS_RST_N,            // System reset, active low
  output reg SYS_INIT,             // Load system registers
  output reg [31:0] START_ADDR     // First fetch after release
);

  // ****************************************
  // Constants and states
  // ****************************************
  localparam [1:0] ST_HOLD = 2'd0;
  localparam [1:0] ST_INIT = 2'd1;
  localparam [1:0] ST_WARM = 2'd2;
  localparam [1:0] ST_RUN = 2'd3;
  localparam [31:0] INIT_M1 = INIT_CYCLES - 1;
  localparam [31:0] WARM_M1 = WARMUP_CYCLES - 1;
  localparam [15:0] INIT_LAST = INIT_M1[15:0];
  localparam [15:0] WARM_LAST = WARM_M1[15:0];
  localparam [1:0] RESP_OK = 2'b00;
  localparam [1:0] RESP_ERR = 2'b10;

  // ****************************************
  // Input synchronisation
  // ****************************************
  wire [2:0] sync_out;
  wire pin_level;
  wire lv_det;
  wire lv_trip;

  // Pin lane runs inverted so a cleared synchroniser reads as released
  rsq_sync3 #(
    .WIDTH(3)
  ) u_sync (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .din({LV_TRIP, LV_DETECT, ~PIN_RST_N}),
    .dout(sync_out)
  );

  assign pin_level = ~sync_out[0];
  assign lv_det = sync_out[1];
  assign lv_trip = sync_out[2];

  // ****************************************
  // Registers, sequencer state and watchdog
  // ****************************************
  reg pin_en;
  reg wdog_en;
  reg [1:0] lv_level;
  reg lvrst_en;
  reg [3:0] rst_flags;
  reg [1:0] irq_st;
  reg [1:0] irq_mask;
  reg lv_det_d;
  reg wdog_kick;
  reg [1:0] state;
  reg [15:0] cnt;
  reg boot_zero;

  wire [WDOG_WIDTH-1:0] wdog_count;
  wire wdog_ovf;
  wire running = (state == ST_RUN);

  rsq_wdog #(
    .WIDTH(WDOG_WIDTH)
  ) u_wdog (
    .clk(CORE_CLK),
    .arst_n(ARST_N),
    .enable(wdog_en & running),
    .clear(wdog_kick | ~running),
    .count(wdog_count),
    .overflow(wdog_ovf)
  );

  // ****************************************
  // Reset causes
  // ****************************************
  // Pin is only a cause while enabled; low level resets, high runs
  wire pin_cause = pin_en & ~pin_level;
  wire lv_cause = lvrst_en & lv_trip;
  wire wd_cause = wdog_ovf & running;
  wire hold_cause = pin_cause | lv_cause;
  wire any_cause = hold_cause | wd_cause;

  // ****************************************
  // Sequencer
  // ****************************************
  reg [1:0] next_state;
  reg [15:0] next_cnt;

  always @* begin
    next_state = state;
    next_cnt = cnt + 16'h0001;
    case (state)
      ST_HOLD: begin
        next_cnt = 16'h0000;
        if (!hold_cause) begin
          next_state = ST_INIT;
        end
      end
      ST_INIT: begin
        if (any_cause) begin
          next_state = ST_HOLD;
        end else if (cnt == INIT_LAST) begin
          next_state = ST_WARM;
          next_cnt = 16'h0000;
        end
      end
      ST_WARM: begin
        if (any_cause) begin
          next_state = ST_HOLD;
        end else if (cnt == WARM_LAST) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_cnt = 16'h0000;
        if (any_cause) begin
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_HOLD;
        next_cnt = 16'h0000;
      end
    endcase
  end

  // SYS_RST_N and SYS_INIT come from the next state so that release lands on a clock edge
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state <= ST_HOLD;
      cnt <= 16'h0000;
      SYS_RST_N <= 1'b0;
      SYS_INIT <= 1'b0;
      boot_zero <= 1'b0;
      START_ADDR <= BOOT_ADDR;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      SYS_RST_N <= (next_state == ST_RUN);
      SYS_INIT <= (next_state == ST_INIT);
      if (any_cause) begin
        // A watchdog-only reset skips the boot loader
        boot_zero <= wd_cause & ~hold_cause;
      end
      START_ADDR <= boot_zero ? 32'h0000_0000 : BOOT_ADDR;
    end
  end

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  wire aw_hs = S_AXI_AWVALID & S_AXI_AWREADY;
  wire w_hs = S_AXI_WVALID & S_AXI_WREADY;
  wire do_write = aw_held & w_held & ~S_AXI_BVALID;
  wire next_aw_held = (aw_held | aw_hs) & ~do_write;
  wire next_w_held = (w_held | w_hs) & ~do_write;
  wire next_bvalid = do_write | (S_AXI_BVALID & ~S_AXI_BREADY);
  wire lane0 = do_write & w_strb[0];
  wire wr_ctrl = lane0 & (aw_addr == `RSQ_OFS_CTRL);
  wire wr_wdog = lane0 & (aw_addr == `RSQ_OFS_WDOG);
  wire wr_rstst = lane0 & (aw_addr == `RSQ_OFS_RSTST);
  wire wr_irqst = lane0 & (aw_addr == `RSQ_OFS_IRQST);
  wire wr_mask = lane0 & (aw_addr == `RSQ_OFS_IRQMSK);
  wire aw_known = (aw_addr == `RSQ_OFS_CTRL) | (aw_addr == `RSQ_OFS_WDOG) |
                  (aw_addr == `RSQ_OFS_RSTST) | (aw_addr == `RSQ_OFS_IRQST) |
                  (aw_addr == `RSQ_OFS_IRQMSK);

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY <= 1'b1;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OK;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      if (aw_hs) begin
        aw_addr <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (w_hs) begin
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      S_AXI_AWREADY <= ~next_aw_held & ~next_bvalid;
      S_AXI_WREADY <= ~next_w_held & ~next_bvalid;
      S_AXI_BVALID <= next_bvalid;
      if (do_write) begin
        S_AXI_BRESP <= aw_known ? RESP_OK : RESP_ERR;
      end
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  wire ar_hs = S_AXI_ARVALID & S_AXI_ARREADY;
  wire next_rvalid = ar_hs | (S_AXI_RVALID & ~S_AXI_RREADY);
  wire [7:0] ar_word = {S_AXI_ARADDR[7:2], 2'b00};
  reg [31:0] rd_mux;
  reg rd_known;

  always @* begin
    rd_mux = 32'h0000_0000;
    rd_known = 1'b1;
    case (ar_word)
      `RSQ_OFS_CTRL: begin
        rd_mux[`RSQ_CTRL_PIN_EN] = pin_en;
        rd_mux[`RSQ_CTRL_WDOG_EN] = wdog_en;
        rd_mux[`RSQ_CTRL_LVL_HI:`RSQ_CTRL_LVL_LO] = lv_level;
        rd_mux[`RSQ_CTRL_LVRST_EN] = lvrst_en;
      end
      `RSQ_OFS_WDOG: begin
        rd_mux[WDOG_WIDTH-1:0] = wdog_count;
      end
      `RSQ_OFS_RSTST: begin
        rd_mux[3:0] = rst_flags;
        rd_mux[`RSQ_RST_LV_LIVE] = lv_det;
      end
      `RSQ_OFS_IRQST: begin
        rd_mux[1:0] = irq_st;
      end
      `RSQ_OFS_IRQMSK: begin
        rd_mux[1:0] = irq_mask;
      end
      default: begin
        rd_known = 1'b0;
      end
    endcase
  end

  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OK;
    end else begin
      S_AXI_ARREADY <= ~next_rvalid;
      S_AXI_RVALID <= next_rvalid;
      if (ar_hs) begin
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= rd_known ? RESP_OK : RESP_ERR;
      end
    end
  end

  // ****************************************
  // Control, flags and interrupt
  // ****************************************
  wire lv_rise = lv_det & ~lv_det_d;
  wire [3:0] rst_set = {1'b0, lv_cause, wd_cause, pin_cause};
  wire [1:0] irq_set = {wd_cause, lv_rise};
  wire [3:0] rst_clr = wr_rstst ? w_data[3:0] : 4'h0;
  wire [1:0] irq_clr = wr_irqst ? w_data[1:0] : 2'b00;

  // Software settings survive the system reset; only power-on clears them
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_en <= 1'b1;
      wdog_en <= 1'b0;
      lv_level <= 2'b00;
      lvrst_en <= 1'b1;
      rst_flags <= `RSQ_RSTST_RESET;
      irq_st <= 2'b00;
      irq_mask <= 2'b00;
      lv_det_d <= 1'b0;
      wdog_kick <= 1'b0;
      LV_RESET_LEVEL <= 2'b00;
      LV_IRQ <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        pin_en <= w_data[`RSQ_CTRL_PIN_EN];
        wdog_en <= w_data[`RSQ_CTRL_WDOG_EN];
        lv_level <= w_data[`RSQ_CTRL_LVL_HI:`RSQ_CTRL_LVL_LO];
        lvrst_en <= w_data[`RSQ_CTRL_LVRST_EN];
      end
      if (wr_mask) begin
        irq_mask <= w_data[1:0];
      end
      wdog_kick <= wr_wdog & w_data[0];
      // A cause in the same cycle as its clear stays recorded
      rst_flags <= (rst_flags & ~rst_clr) | rst_set;
      irq_st <= (irq_st & ~irq_clr) | irq_set;
      lv_det_d <= lv_det;
      LV_RESET_LEVEL <= lv_level;
      LV_IRQ <= lv_det;
      IRQ <= |(((irq_st & ~irq_clr) | irq_set) & irq_mask);
    end
  end

endmodule

// ### sim/rsq_top_chk.sv
/*
  Checker for the reset sequencer: phase lengths, detector request,
  trip hold and register-bus answers, seen at the top ports only.
  Assumes a bind to rsq_top with the same phase-count parameters.
*/
`timescale 1ns/100ps

module rsq_top_chk #(
  parameter INIT_CYCLES = 4,
  parameter WARMUP_CYCLES = 8
) (
  input wire CORE_CLK,           // Clock
  input wire ARST_N,             // Reset
  input wire S_AXI_BVALID,       // B valid
  input wire S_AXI_BREADY,       // B ready
  input wire [1:0] S_AXI_BRESP,  // B code
  input wire S_AXI_ARVALID,      // AR valid
  input wire S_AXI_ARREADY,      // AR ready
  input wire S_AXI_RVALID,       // R valid
  input wire S_AXI_RREADY,       // R ready
  input wire [31:0] S_AXI_RDATA, // R data
  input wire LV_DETECT,          // Low supply
  input wire LV_TRIP,            // Trip level
  input wire LV_IRQ,             // Detector request
  input wire IRQ,                // Interrupt
  input wire SYS_RST_N,          // System reset
  input wire SYS_INIT,           // Init phase
  input wire [31:0] START_ADDR   // First fetch
);
  reg [15:0] init_cnt;
  reg [15:0] warm_cnt;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  // ****************
  // Phase counters
  // ****************
  // Warm count restarts at every init, so a release without init fails
  always @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      init_cnt <= 16'h0;
      warm_cnt <= 16'h0;
    end else begin
      init_cnt <= SYS_INIT ? init_cnt + 16'h1 : 16'h0;
      warm_cnt <= SYS_INIT ? 16'h0 : (SYS_RST_N ? warm_cnt : warm_cnt + 16'h1);
    end
  end

  property p_init_held;
    SYS_INIT |-> !SYS_RST_N;
  endproperty
  a_init_held: assert property (p_init_held) else $error("init phase while released");
  property p_init_len;
    $fell(SYS_INIT) |-> init_cnt == INIT_CYCLES;
  endproperty
  a_init_len: assert property (p_init_len) else $error("init phase length wrong");
  property p_warm_len;
    $rose(SYS_RST_N) |-> warm_cnt == WARMUP_CYCLES;
  endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm-up length wrong");
  property p_lv_on;
    LV_DETECT [*8] |-> LV_IRQ;
  endproperty
  a_lv_on: assert property (p_lv_on) else $error("detector request missing");
  property p_lv_off;
    !LV_DETECT [*8] |-> !LV_IRQ;
  endproperty
  a_lv_off: assert property (p_lv_off) else $error("detector request stuck");
  property p_trip;
    LV_TRIP [*8] |-> !SYS_RST_N && !SYS_INIT;
  endproperty
  a_trip: assert property (p_trip) else $error("trip level not holding reset");
  property p_b_hold;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_lat;
    S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read answer late");
  property p_r_hold;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");

  c_wdog_start: cover property ($rose(SYS_RST_N) && START_ADDR == 32'h0);
  c_irq: cover property ($rose(IRQ));
  c_slverr: cover property (S_AXI_BVALID && S_AXI_BRESP == 2'b10);
endmodule

// ### sim/rsq_far_model.sv
/*
  Far-side model: reset pin driver and supply detector outputs.
  Assumes the bench sets the commands just after a rising edge.
*/
`timescale 1ns/100ps

module rsq_far_model (
  input wire clk,          // Bench clock
  input wire pin_hold,     // Hold the pin low
  input wire below_det,    // Supply under detect level
  input wire below_trip,   // Supply under reset level
  output reg pin_rst_n,    // Reset pin
  output reg lv_detect,    // Detector flag
  output reg lv_trip       // Trip flag
);
  initial begin
    pin_rst_n = 1'b1;
    lv_detect = 1'b0;
    lv_trip = 1'b0;
  end

  // One edge of lag, like a slow board-level driver
  always @(posedge clk) begin
    pin_rst_n <= !pin_hold;
    lv_detect <= below_det;
    lv_trip <= below_trip;
  end
endmodule

// ### sim/tb_rsq_top.sv
/*
  Bench of the reset sequencer: register-bus master, queued expectations
  and a watching process. Assumes the far-side model and the checker.
*/
`timescale 1ns/100ps

module tb_rsq_top;
  localparam [31:0] BOOT = 32'h1fff_0000;
  reg clk, arst_n, awvalid, wvalid, bready, arvalid, rready, run_q;
  reg pin_hold, below_det, below_trip;
  reg [7:0] awaddr, araddr;
  reg [31:0] wdata, lvl;
  reg [3:0] wstrb;
  wire awready, wready, bvalid, arready, rvalid, pin_n, lv_det, lv_trip;
  wire lv_irq, irq, sys_rst_n, sys_init;
  wire [1:0] bresp, rresp, lv_lvl;
  wire [31:0] rdata, start_addr;
  integer miscompares, check_count, i;
  reg [33:0] exp_rd[$];
  reg [1:0] exp_b[$];
  reg [31:0] exp_start[$];

  rsq_top #(.WDOG_WIDTH(6), .INIT_CYCLES(4), .WARMUP_CYCLES(8), .BOOT_ADDR(BOOT)) dut (
    .CORE_CLK(clk), .ARST_N(arst_n), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_AWADDR(awaddr), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_WDATA(wdata),
    .S_AXI_WSTRB(wstrb), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_BRESP(bresp),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_ARADDR(araddr),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .PIN_RST_N(pin_n), .LV_DETECT(lv_det), .LV_TRIP(lv_trip), .LV_RESET_LEVEL(lv_lvl),
    .LV_IRQ(lv_irq), .IRQ(irq), .SYS_RST_N(sys_rst_n), .SYS_INIT(sys_init),
    .START_ADDR(start_addr));
  rsq_far_model far (.clk(clk), .pin_hold(pin_hold), .below_det(below_det),
    .below_trip(below_trip), .pin_rst_n(pin_n), .lv_detect(lv_det), .lv_trip(lv_trip));

  // ****************
  // Compare and bus tasks
  // ****************
  task report(input ok, input [33:0] got, input [33:0] exp);
    begin
      check_count = check_count + 1;
      if (!ok) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task cmp_rd(input [33:0] got, input [33:0] exp); report(got === exp, got, exp); endtask
  task cmp_b(input [1:0] got, input [1:0] exp); report(got === exp, got, exp); endtask
  task cmp_sig(input [31:0] got, input [31:0] exp); report(got === exp, got, exp); endtask

  task wr(input [7:0] a, input [31:0] d, input [1:0] r);
    reg [31:0] rn;
    begin
      exp_b.push_back(r);
      rn = $urandom;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      wstrb <= {rn[2:0], 1'b1};
      fork
        begin
          do @(posedge clk); while (!awready);
          awvalid <= 1'b0;
        end
        begin
          do @(posedge clk); while (!wready);
          wvalid <= 1'b0;
        end
      join
      repeat (rn[4:3]) @(posedge clk);
      bready <= 1'b1;
      do @(posedge clk); while (!bvalid);
      bready <= 1'b0;
    end
  endtask

  task rd(input [7:0] a, input [33:0] e);
    reg [31:0] rn;
    begin
      exp_rd.push_back(e);
      rn = $urandom;
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      repeat (rn[1:0]) @(posedge clk);
      rready <= 1'b1;
      do @(posedge clk); while (!rvalid);
      rready <= 1'b0;
    end
  endtask

  task run_up;
    do @(posedge clk); while (!sys_rst_n);
  endtask

  task end_of_test;
    begin
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  // ****************
  // Watching process
  // ****************
  always @(posedge clk) begin
    run_q <= sys_rst_n;
    if (rvalid && rready) cmp_rd({rresp, rdata}, exp_rd.pop_front());
    if (bvalid && bready) cmp_b(bresp, exp_b.pop_front());
    if (sys_rst_n && !run_q) cmp_sig(start_addr, exp_start.pop_front());
  end

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  initial begin
    #40000;
    miscompares = miscompares + 1;
    end_of_test;
  end

  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    {pin_hold, below_det, below_trip, awaddr, araddr, wdata, wstrb} = 55'h0;
    miscompares = 0;
    check_count = 0;
    lvl = $urandom(32'h2809c275);
    exp_start.push_back(BOOT);
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    run_up;
    rd(8'h00, {2'b00, 32'h11});
    rd(8'h08, {2'b00, 32'h8});
    rd(8'h10, 34'h0);
    rd(8'h14, {2'b10, 32'h0});
    wr(8'h14, $urandom, 2'b10);
    // Pin reset while running, then with the pin function off
    exp_start.push_back(BOOT);
    pin_hold <= 1'b1;
    repeat (20) @(posedge clk);
    cmp_sig({31'h0, sys_rst_n}, 32'h0);
    pin_hold <= 1'b0;
    run_up;
    rd(8'h08, {2'b00, 32'h9});
    wr(8'h08, 32'hf, 2'b00);
    rd(8'h08, 34'h0);
    wr(8'h00, 32'h10, 2'b00);
    pin_hold <= 1'b1;
    repeat (20) @(posedge clk);
    cmp_sig({31'h0, sys_rst_n}, 32'h1);
    pin_hold <= 1'b0;
    repeat (10) @(posedge clk);
    wr(8'h00, 32'h11, 2'b00);
    // Watchdog kicked in time, then left to overflow
    wr(8'h10, 32'h3, 2'b00);
    wr(8'h00, 32'h13, 2'b00);
    for (i = 0; i < 6; i = i + 1) begin
      repeat (30) @(posedge clk);
      wr(8'h04, 32'h1, 2'b00);
    end
    cmp_sig({31'h0, sys_rst_n}, 32'h1);
    exp_start.push_back(32'h0);
    while (sys_rst_n) @(posedge clk);
    wr(8'h00, 32'h11, 2'b00);
    run_up;
    rd(8'h08, {2'b00, 32'h2});
    rd(8'h0c, {2'b00, 32'h2});
    cmp_sig({31'h0, irq}, 32'h1);
    wr(8'h10, 32'h1, 2'b00);
    // Interrupt output follows the new mask one edge after the write lands
    @(posedge clk);
    cmp_sig({31'h0, irq}, 32'h0);
    wr(8'h0c, 32'h2, 2'b00);
    wr(8'h08, 32'hf, 2'b00);
    // Supply dips under the detect level only
    below_det <= 1'b1;
    repeat (10) @(posedge clk);
    cmp_sig({31'h0, lv_irq}, 32'h1);
    cmp_sig({31'h0, irq}, 32'h1);
    rd(8'h08, {2'b00, 32'h10});
    rd(8'h0c, {2'b00, 32'h1});
    below_det <= 1'b0;
    wr(8'h0c, 32'h1, 2'b00);
    // Second threshold at a random level forces a reset
    wr(8'h00, {27'h0, 1'b1, lvl[1:0], 2'b01}, 2'b00);
    @(posedge clk);
    cmp_sig({30'h0, lv_lvl}, {30'h0, lvl[1:0]});
    exp_start.push_back(BOOT);
    below_trip <= 1'b1;
    repeat (20) @(posedge clk);
    cmp_sig({31'h0, sys_rst_n}, 32'h0);
    below_trip <= 1'b0;
    run_up;
    rd(8'h08, {2'b00, 32'h4});
    end_of_test;
  end
endmodule

bind rsq_top rsq_top_chk #(.INIT_CYCLES(INIT_CYCLES), .WARMUP_CYCLES(WARMUP_CYCLES)) u_chk (
  .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID),
  .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .LV_DETECT(LV_DETECT), .LV_TRIP(LV_TRIP), .LV_IRQ(LV_IRQ),
  .IRQ(IRQ), .SYS_RST_N(SYS_RST_N), .SYS_INIT(SYS_INIT), .START_ADDR(START_ADDR));
